/* pkg/long_timer_params.svh */
`ifndef LONG_TIMER_PARAMS_SVH
`define LONG_TIMER_PARAMS_SVH
`define LT_ADDR_CTRL     12'h008
`define LT_ADDR_RELOAD   12'h00c
`define LT_ADDR_CAPTURE  12'h010
`define LT_ADDR_COUNT    12'h014
`define LT_BIT_OUT_SEL   0
`define LT_BIT_TO_IE     1
`define LT_BIT_CAP_IE    2
`define LT_BIT_PS_LO     3
`define LT_BIT_PS_HI     4
`define LT_BIT_TO_FLAG   5
`define LT_BIT_MODE      6
`define LT_BIT_ENABLE    7
`define LT_CTRL_RESET    8'h00
`define LT_COUNT_ALL_ONE 16'hffff
`define LT_COUNT_ZERO    16'h0000
`define LT_RELOAD_RESET  16'hffff
`endif

/* pkg/long_timer_pkg.sv */
package long_timer_pkg;
  typedef enum logic [1:0] {
    PS_DIV1,
    PS_DIV2,
    PS_DIV4,
    PS_DIV8
  } prescale_e;
  typedef enum logic {
    OP_TRANSMIT,
    OP_DEMOD
  } op_mode_e;
endpackage

/* hw/long_timer_prescaler.sv */
`timescale 1ns/1ps
`include "long_timer_params.svh"
module long_timer_prescaler (
  input  wire logic                          sys_clk,
  input  wire logic                          resetn,
  input  wire logic                          run,
  input  wire long_timer_pkg::prescale_e     sel,
  output logic                               tick
);
  logic [2:0] div_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 3'h0;
    end else if (!run) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  always_comb begin
    case (sel)
      long_timer_pkg::PS_DIV1: tick = run;
      long_timer_pkg::PS_DIV2: tick = run && (div_q[0] == 1'b1);
      long_timer_pkg::PS_DIV4: tick = run && (div_q[1:0] == 2'h3);
      long_timer_pkg::PS_DIV8: tick = run && (div_q == 3'h7);
      default:                 tick = 1'b0;
    endcase
  end
endmodule

/* hw/long_timer_edge_sync.sv */
`timescale 1ns/1ps
module long_timer_edge_sync (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic pin_in,
  input  wire logic rise_en,
  input  wire logic fall_en,
  output logic      edge_seen
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign edge_seen = (rise_en && sync_q && !last_q) || (fall_en && !sync_q && last_q);
endmodule

/* hw/long_timer_control.sv */
`timescale 1ns/1ps
`include "long_timer_params.svh"
module long_timer_control (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        demod_mode,
  input  wire logic        ping_pong,
  input  wire logic        demod_pin,
  input  wire logic        edge_rise_en,
  input  wire logic        edge_fall_en,
  input  wire logic        eight_bit_timer_timeout,
  input  wire logic        port_three_line_five_data,
  output logic             port_three_line_five,
  output logic             long_timer_output,
  output logic             timeout_irq,
  output logic             capture_irq,
  output logic             eight_bit_timer_restart
);
  logic [7:0]  ctrl_q;
  logic [15:0] reload_q;
  logic [15:0] count_q;
  logic [15:0] capture_q;
  logic        to_flag_q;
  logic        run_q;
  logic        armed_q;
  logic        demod_q;
  logic        pp_q;
  logic        t8_to_q;
  logic        tick;
  logic        edge_seen;
  logic        wr_ctrl;
  logic        wr_reload;
  logic        setup_ph;
  logic        access_wr;
  logic        rd_ok;
  logic        at_zero;
  logic        timeout_ev;
  logic        capture_ev;
  logic        reload_ev;
  logic        stop_ev;
  logic        mode_bit;
  logic [31:0] rd_mux;
  long_timer_pkg::prescale_e ps_sel;

  assign setup_ph  = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  assign wr_ctrl   = access_wr && (paddr == `LT_ADDR_CTRL);
  assign wr_reload = access_wr && (paddr == `LT_ADDR_RELOAD);
  assign mode_bit  = ctrl_q[`LT_BIT_MODE];
  assign ps_sel    = long_timer_pkg::prescale_e'(ctrl_q[`LT_BIT_PS_HI:`LT_BIT_PS_LO]);
  assign at_zero   = tick && (count_q == `LT_COUNT_ZERO);

  // Mode pins come from same-clock timer logic; sampled once to keep outputs registered
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      demod_q <= 1'b0;
    end else begin
      demod_q <= demod_mode;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pp_q <= 1'b0;
    end else begin
      pp_q <= ping_pong;
    end
  end

  // Registered once like the mode pins; the edge capture path through the synchroniser takes one cycle more
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      t8_to_q <= 1'b0;
    end else begin
      t8_to_q <= eight_bit_timer_timeout;
    end
  end

  long_timer_prescaler u_prescaler (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .run     (run_q),
    .sel     (ps_sel),
    .tick    (tick)
  );

  long_timer_edge_sync u_edge (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .pin_in    (demod_pin),
    .rise_en   (edge_rise_en),
    .fall_en   (edge_fall_en),
    .edge_seen (edge_seen)
  );

  // Mode bit meaning depends on which operation is active
  always_comb begin
    timeout_ev = 1'b0;
    capture_ev = 1'b0;
    reload_ev  = 1'b0;
    stop_ev    = 1'b0;
    if (run_q) begin
      if (demod_q == 1'b1) begin
        timeout_ev = at_zero;
        if (!mode_bit && edge_seen) begin
          capture_ev = 1'b1;
          reload_ev  = 1'b1;
        end else if (mode_bit && armed_q && edge_seen) begin
          capture_ev = 1'b1;
          reload_ev  = 1'b1;
        end else if (mode_bit && t8_to_q) begin
          capture_ev = 1'b1;
        end
      end else begin
        // Transmit: every terminal count reloads; single pass also stops the run bit
        timeout_ev = at_zero;
        reload_ev  = at_zero;
        stop_ev    = at_zero && mode_bit;
      end
    end
  end

  // Run bit: software start/stop and single pass end; ping-pong does not set or clear it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run_q <= 1'b0;
    end else if (wr_ctrl) begin
      run_q <= pwdata[`LT_BIT_ENABLE];
    end else if (stop_ev) begin
      run_q <= 1'b0;
    end
  end

  // Other control bits; enable and flag are kept in their own registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `LT_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[7:0];
    end
  end

  // A zero then one written to the ignore bit arms one more edge capture
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      armed_q <= 1'b0;
    end else if (wr_ctrl && pwdata[`LT_BIT_MODE] && !mode_bit) begin
      armed_q <= 1'b1;
    end else if (capture_ev && reload_ev) begin
      armed_q <= 1'b0;
    end else if (wr_ctrl && !pwdata[`LT_BIT_MODE]) begin
      armed_q <= 1'b0;
    end
  end

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      to_flag_q <= 1'b0;
    end else if (timeout_ev) begin
      to_flag_q <= 1'b1;
    end else if (wr_ctrl && pwdata[`LT_BIT_TO_FLAG]) begin
      to_flag_q <= 1'b0;
    end
  end

  // A new reload value waits for the next load; the running count is left alone
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reload_q <= `LT_RELOAD_RESET;
    end else if (wr_reload) begin
      reload_q <= pwdata[15:0];
    end
  end

  // Enable from stopped loads the reload value; an enable write while running keeps the count
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= `LT_COUNT_ALL_ONE;
    end else if (wr_ctrl && pwdata[`LT_BIT_ENABLE] && !run_q) begin
      count_q <= reload_q;
    // Edge reload beats the wrap, so an edge capture restarts the measurement; an 8-bit timeout capture does not
    end else if (reload_ev && demod_q) begin
      count_q <= reload_q;
    end else if (at_zero && run_q) begin
      if (demod_q) begin
        count_q <= `LT_COUNT_ALL_ONE;
      end else begin
        count_q <= reload_q;
      end
    end else if (tick) begin
      count_q <= count_q - 16'h0001;
    end
  end

  // Capture is a plain copy; the count is disturbed only by the reload that comes with an edge capture
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      capture_q <= `LT_COUNT_ZERO;
    end else if (capture_ev) begin
      capture_q <= count_q;
    end
  end

  // Interrupt pulses, each gated by its enable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      timeout_irq <= 1'b0;
    end else begin
      timeout_irq <= timeout_ev && ctrl_q[`LT_BIT_TO_IE];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      capture_irq <= 1'b0;
    end else begin
      capture_irq <= capture_ev && ctrl_q[`LT_BIT_CAP_IE];
    end
  end

  // Hand-back pulse lets the 8-bit timer take its turn in ping-pong
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      eight_bit_timer_restart <= 1'b0;
    end else begin
      eight_bit_timer_restart <= stop_ev && pp_q;
    end
  end

  // Timer output toggles each terminal count in transmit operation
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      long_timer_output <= 1'b0;
    end else if (run_q && !demod_q && at_zero) begin
      long_timer_output <= !long_timer_output;
    end
  end

  // Pin follows the timer output or the port value, one cycle late either way
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port_three_line_five <= 1'b0;
    end else if (ctrl_q[`LT_BIT_OUT_SEL]) begin
      port_three_line_five <= long_timer_output;
    end else begin
      port_three_line_five <= port_three_line_five_data;
    end
  end

  // Mode switches while running are not guarded; software stops first
  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `LT_ADDR_CTRL: begin
        rd_mux[7:0]            = ctrl_q;
        rd_mux[`LT_BIT_ENABLE] = run_q;
        rd_mux[`LT_BIT_TO_FLAG] = to_flag_q;
      end
      `LT_ADDR_RELOAD:  rd_mux[15:0] = reload_q;
      `LT_ADDR_CAPTURE: rd_mux[15:0] = capture_q;
      `LT_ADDR_COUNT:   rd_mux[15:0] = count_q;
      default:          rd_ok = 1'b0;
    endcase
  end

  // Zero-wait slave: answer in the first access cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_ph;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_ph && !rd_ok;
    end
  end

  // Read data is zero outside a read access so stale values never show
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (setup_ph && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end
endmodule

/* test/long_timer_control_assertions.sv */
`timescale 1ns/1ps
module long_timer_control_assertions (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        demod_mode,
  input wire logic        port_three_line_five_data,
  input wire logic        port_three_line_five,
  input wire logic        long_timer_output,
  input wire logic        timeout_irq,
  input wire logic        capture_irq
);
  // Shadow of the select and enable bits, so the checker needs no internal probes
  logic [2:0] sel_q;
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn) sel_q <= 3'h0;
    else if (psel && penable && pready && pwrite && paddr == 12'h008) sel_q <= pwdata[2:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_pin_port: assert property ($past(resetn) && !$past(sel_q[0]) |->
    port_three_line_five == $past(port_three_line_five_data)) else $error("pin not port data");
  a_pin_timer: assert property ($past(resetn) && $past(sel_q[0]) |->
    port_three_line_five == $past(long_timer_output)) else $error("pin not timer output");
  a_timeout_gate: assert property (!$past(sel_q[1]) && !$past(sel_q[1], 2) |-> !timeout_irq)
    else $error("timeout irq while disabled");
  a_capture_gate: assert property (!$past(sel_q[2]) && !$past(sel_q[2], 2) |-> !capture_irq)
    else $error("capture irq while disabled");
  a_capture_demod: assert property (capture_irq |-> $past(demod_mode, 2))
    else $error("capture outside demodulation");
  a_irq_pulse: assert property (timeout_irq |=> !timeout_irq)
    else $error("timeout irq not a pulse");
  a_ready_access: assert property (psel && penable |-> pready) else $error("no ready in access");
  a_err_map: assert property (pready |-> pslverr == !(paddr inside {12'h008, 12'h00c, 12'h010, 12'h014}))
    else $error("error response wrong");
  cover property (timeout_irq);
  cover property (capture_irq);
  cover property (pready && pslverr);
endmodule
bind long_timer_control long_timer_control_assertions chk_u (.sys_clk, .resetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .demod_mode, .port_three_line_five_data, .port_three_line_five,
  .long_timer_output, .timeout_irq, .capture_irq);

/* test/long_timer_control_tb.sv */
`timescale 1ns/1ps
module long_timer_control_tb;
  logic        sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        demod_mode = 1'b0, ping_pong = 1'b0, demod_pin = 1'b0, edge_rise_en = 1'b1;
  logic        edge_fall_en = 1'b1, eight_bit_timer_timeout = 1'b0, port_three_line_five_data = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic        pready, pslverr, port_three_line_five, long_timer_output, timeout_irq, capture_irq;
  logic        eight_bit_timer_restart, er, lo_q = 1'b0;
  int          n_mismatch = 0, tests_run = 0, n_to = 0, n_cap = 0, n_rs = 0, n_tg = 0, c0, c1;
  longint      t0, t1, base;
  always #10 sys_clk = ~sys_clk;
  long_timer_control dut_u (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .demod_mode, .ping_pong, .demod_pin, .edge_rise_en, .edge_fall_en,
    .eight_bit_timer_timeout, .port_three_line_five_data, .port_three_line_five, .long_timer_output,
    .timeout_irq, .capture_irq, .eight_bit_timer_restart);
  always @(posedge sys_clk) begin
    if (timeout_irq === 1'b1) n_to++;
    if (capture_irq === 1'b1) n_cap++;
    if (eight_bit_timer_restart === 1'b1) n_rs++;
    if (long_timer_output !== lo_q) begin
      n_tg++;
      t1 = t0;
      t0 = $time;
    end
    lo_q = long_timer_output;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic wait_tg(input int k);
    int s = n_tg;
    int n = 0;
    while (n_tg < s + k && n++ < 3000) @(posedge sys_clk);
  endtask
  task automatic edge_in;
    demod_pin <= ~demod_pin;
    cyc(8);
  endtask
  task automatic pulse8;
    eight_bit_timer_timeout <= 1'b1;
    cyc(1);
    eight_bit_timer_timeout <= 1'b0;
    cyc(8);
  endtask
  function automatic logic [31:0] ctl(input logic [7:0] b, input logic [1:0] ps);
    return {24'h0, b | {3'b000, ps, 3'b000}};
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc(20000);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    rv = $urandom(32'h2ca2);
    cyc(6);
    resetn <= 1'b1;
    cyc(1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rv, 32'h0, "ctrl reset");
    apb(1'b0, 12'h00c, 32'h0);
    chk(rv, 32'hffff, "reload reset");
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped");
    $display("test reset finished");
    c0 = 2 + $urandom % 6;
    apb(1'b1, 12'h00c, c0);
    // Modulo periods must scale exactly with the divider, whatever the tick phase
    for (int ps = 0; ps < 4; ps++) begin
      c1 = n_to;
      apb(1'b1, 12'h008, ctl({6'h20, ps[0], 1'b1}, ps[1:0]));
      wait_tg(3);
      if (ps == 0) base = t0 - t1;
      chk(32'(t0 - t1), 32'(base << ps), "period");
      chk(n_to > c1, ps[0], "timeout irq gate");
      apb(1'b0, 12'h008, 32'h0);
      chk(rv[7], 1'b1, "running");
      apb(1'b1, 12'h008, 32'h20);
    end
    port_three_line_five_data <= 1'($urandom);
    cyc(2);
    chk(port_three_line_five, port_three_line_five_data, "port data");
    $display("test prescale finished");
    apb(1'b1, 12'h008, 32'hc0);
    wait_tg(1);
    cyc(4);
    apb(1'b0, 12'h008, 32'h0);
    chk(rv, 32'h60, "single pass stop");
    apb(1'b1, 12'h008, 32'h40);
    apb(1'b0, 12'h008, 32'h0);
    chk(rv, 32'h60, "flag kept");
    apb(1'b1, 12'h008, 32'h60);
    apb(1'b0, 12'h008, 32'h0);
    chk(rv, 32'h40, "flag cleared");
    $display("test single pass finished");
    demod_mode <= 1'b1;
    apb(1'b1, 12'h00c, 32'hffff);
    apb(1'b1, 12'h008, 32'h84);
    edge_rise_en <= 1'b0;
    c1 = n_cap;
    edge_in;
    edge_in;
    chk(n_cap - c1, 1, "falling edge only");
    edge_rise_en <= 1'b1;
    apb(1'b1, 12'h008, 32'hc4);
    c1 = n_cap;
    edge_in;
    edge_in;
    edge_in;
    chk(n_cap - c1, 1, "rearm one edge");
    c1 = n_cap;
    pulse8;
    chk(n_cap - c1, 1, "eight bit timeout capture");
    apb(1'b0, 12'h010, 32'h0);
    c0 = rv;
    apb(1'b0, 12'h014, 32'h0);
    chk(rv < c0 && c0 < 32'hffff, 1, "count runs on past capture");
    apb(1'b1, 12'h008, 32'hc0);
    c1 = n_cap;
    pulse8;
    chk(n_cap - c1, 0, "capture masked");
    apb(1'b1, 12'h008, 32'h20);
    apb(1'b1, 12'h00c, 32'h5);
    c1 = n_to;
    apb(1'b1, 12'h008, 32'h82);
    cyc(30);
    apb(1'b0, 12'h008, 32'h0);
    chk(rv & 32'ha0, 32'ha0, "wrap keeps running");
    chk(n_to > c1, 1, "demod timeout");
    apb(1'b0, 12'h014, 32'h0);
    chk(rv > 32'hff00, 1, "count wrapped to all ones");
    $display("test demodulation finished");
    apb(1'b1, 12'h008, 32'h20);
    demod_mode <= 1'b0;
    ping_pong <= 1'b1;
    c1 = n_rs;
    apb(1'b1, 12'h008, 32'hc0);
    cyc(30);
    chk(n_rs > c1, 1, "hand back");
    $display("test ping pong finished");
    end_of_test;
  end
endmodule
